// ===== logic/flag_guard.sv
// one status flag with a two-step clear that respects break protection
`timescale 1ns/1ns
`default_nettype none
module flag_guard (
   input wire logic ref_clk,
   input wire logic sys_rst,
   flag_guard_if.guard fg
);
   logic flag_q;
   logic armed_q;
   wire clear_allowed = !fg.break_mode || fg.clear_enable;
   wire do_clear = armed_q && fg.second_step && clear_allowed;
   assign fg.flag = flag_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flag_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         // set wins over clear; a cleared flag stays cleared after break
         flag_q <= fg.set_event | (flag_q & ~do_clear);
         if (fg.set_event || do_clear) begin
            armed_q <= 1'b0;
         end else if (fg.first_step && flag_q) begin
            armed_q <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== logic/flag_guard_if.sv
// break protection signals between the top and the flag guard
`timescale 1ns/1ns
`default_nettype none
interface flag_guard_if;
   logic break_mode;
   logic clear_enable;
   logic first_step;
   logic second_step;
   logic set_event;
   logic flag;
   modport top (output break_mode, output clear_enable, output first_step, output second_step,
      output set_event, input flag);
   modport guard (input break_mode, input clear_enable, input first_step, input second_step,
      input set_event, output flag);
endinterface
`default_nettype wire

// ===== logic/standby_reset_defs.svh
// offsets, field positions and timing counts of the standby and reset status block
`ifndef STANDBY_RESET_DEFS_SVH
`define STANDBY_RESET_DEFS_SVH

// register word indexes; the byte address on the bus is index * 4
`define IDX_BREAK_STATUS 16'hFE00
`define IDX_RESET_CAUSE 16'hFE01
`define IDX_BREAK_FLAG_CLEAR 16'hFE03
`define IDX_CONTROL 16'hFE08
`define IDX_STATE 16'hFE09
`define ADDR_WIDTH 18

// break status fields
`define BSTAT_STANDBY_BIT 1
// reset cause fields
`define RC_LOW_VOLTAGE 1
`define RC_MONITOR 2
`define RC_ILLEGAL_ADDR 3
`define RC_ILLEGAL_OP 4
`define RC_WATCHDOG 5
`define RC_PIN 6
`define RC_POWER_ON 7
// break flag clear control fields
`define BFC_ENABLE_BIT 7
// control register fields
`define CTL_SHORT_RECOVERY 0
`define CTL_WATCHDOG_DISABLE 1
`define CTL_EMULATION 2

// stop recovery in quadrupled bus clock cycles; this block runs on that clock
`define LONG_RECOVERY_CYCLES 4096
`define SHORT_RECOVERY_CYCLES 32
`define COUNTER_WIDTH 13
`define ERASED_BYTE 8'hFF

`endif

// ===== logic/standby_reset_pkg.sv
// types shared by the standby and reset status logic
package standby_reset_pkg;
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_WAIT,
      MODE_STOP,
      MODE_RECOVER
   } power_mode_type;
endpackage

// ===== logic/standby_reset_status.sv
// standby, stop recovery, break flag protection and reset cause status
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "standby_reset_defs.svh"
module standby_reset_status #(
   parameter int LONG_RECOVERY = `LONG_RECOVERY_CYCLES,
   parameter int SHORT_RECOVERY = `SHORT_RECOVERY_CYCLES,
   parameter int COUNT_WIDTH = `COUNTER_WIDTH
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [`ADDR_WIDTH-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // processor side
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic irq_pending,
   output logic mask_clear,
   output logic cpu_clock_enable,
   output logic periph_clock_enable,
   output logic bus_clock_double_enable,
   output logic bus_clock_quad_enable,
   output logic stack_start,
   output logic watchdog_enable,
   output logic [COUNT_WIDTH-1:0] counter_value,
   output logic standby_mode,
   output logic [1:0] power_state,
   // break module and resets (pins, synchronised)
   input wire logic break_irq,
   input wire logic power_on_event,
   input wire logic pin_reset_event,
   input wire logic watchdog_reset_event,
   input wire logic illegal_op_event,
   input wire logic illegal_addr_event,
   input wire logic low_voltage_event,
   input wire logic irq_at_test_voltage,
   input wire logic [7:0] vector_high,
   input wire logic [7:0] vector_low,
   // a peripheral flag with two-step clear, guarded in break
   input wire logic periph_flag_set,
   input wire logic periph_clear_first,
   input wire logic periph_clear_second,
   output logic periph_flag
);
   import standby_reset_pkg::*;

   localparam int SYNC_N = 10;
   localparam logic [COUNT_WIDTH-1:0] LONG_LAST = COUNT_WIDTH'(LONG_RECOVERY - 1);
   localparam logic [COUNT_WIDTH-1:0] SHORT_LAST = COUNT_WIDTH'(SHORT_RECOVERY - 1);

   // two-flop synchronisers for the break, reset event, test voltage, interrupt, flag set and vector inputs
   logic [SYNC_N-1:0] meta_q;
   logic [SYNC_N-1:0] sync_q;
   wire [SYNC_N-1:0] raw_in = {break_irq, power_on_event, pin_reset_event, watchdog_reset_event,
      illegal_op_event, illegal_addr_event, low_voltage_event, irq_at_test_voltage,
      irq_pending, periph_flag_set};
   wire brk_s = sync_q[9];
   wire por_s = sync_q[8];
   wire pin_s = sync_q[7];
   wire wdt_s = sync_q[6];
   wire illegal_opcode_flag_s = sync_q[5];
   wire illegal_address_flag_s = sync_q[4];
   wire lvi_s = sync_q[3];
   wire tst_s = sync_q[2];
   wire irq_s = sync_q[1];
   wire pset_s = sync_q[0];
   logic [7:0] vec_hi_meta_q, vec_hi_q, vec_lo_meta_q, vec_lo_q;

   always_ff @(posedge ref_clk) begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      vec_hi_meta_q <= vector_high;
      vec_hi_q <= vec_hi_meta_q;
      vec_lo_meta_q <= vector_low;
      vec_lo_q <= vec_lo_meta_q;
   end

   // register storage
   logic bfc_enable_q;
   logic [2:0] ctl_q;
   logic [7:0] cause_q, cause_d;
   logic standby_flag_q, standby_flag_d;
   power_mode_type mode_q, mode_d;
   logic [COUNT_WIDTH-1:0] count_q, count_d;
   logic mask_clear_q, stack_q, stack_d;
   logic [31:0] rdata_q;
   logic wait_q;
   logic wreq_q;
   logic por_seen_q;

   // avalon: one wait cycle, then answer on the second edge
   wire access = avs_read || avs_write;
   wire done = access && wait_q;
   wire [15:0] idx = avs_address[`ADDR_WIDTH-1:2];
   wire hit_bstat = idx == `IDX_BREAK_STATUS;
   wire hit_cause = idx == `IDX_RESET_CAUSE;
   wire hit_bfc = idx == `IDX_BREAK_FLAG_CLEAR;
   wire hit_ctl = idx == `IDX_CONTROL;
   wire hit_state = idx == `IDX_STATE;
   wire wr_done = done && avs_write;
   wire rd_done = done && avs_read;

   wire short_rec = ctl_q[`CTL_SHORT_RECOVERY];
   wire emulation = ctl_q[`CTL_EMULATION];
   wire in_break = brk_s;
   wire clear_ok = !in_break || bfc_enable_q;

   wire [7:0] bstat_view = 8'(standby_flag_q) << `BSTAT_STANDBY_BIT;
   wire [7:0] bfc_view = 8'(bfc_enable_q) << `BFC_ENABLE_BIT;
   wire [31:0] rdata_d = hit_bstat ? {24'h0, bstat_view} :
                         hit_cause ? {24'h0, cause_q} :
                         hit_bfc ? {24'h0, bfc_view} :
                         hit_ctl ? {29'h0, ctl_q} :
                         hit_state ? {30'h0, mode_q} : 32'h0;

   // first edge of an access: insert the wait cycle and capture read data early
   wire first_cycle = access && !wait_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wait_q <= 1'b0;
         wreq_q <= 1'b1;
      end else begin
         wait_q <= first_cycle;
         wreq_q <= !first_cycle;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata_q <= 32'h0;
      end else if (rd_done || first_cycle) begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bfc_enable_q <= 1'b0;
         ctl_q <= 3'h0;
      end else if (wr_done && hit_bfc) begin
         bfc_enable_q <= avs_writedata[`BFC_ENABLE_BIT];
      end else if (wr_done && hit_ctl) begin
         ctl_q <= avs_writedata[2:0];
      end
   end

   // reset cause flags; reads clear them unless protected by break
   wire vec_erased = vec_hi_q == `ERASED_BYTE && vec_lo_q == `ERASED_BYTE;
   wire monitor_set = por_seen_q && vec_erased && !tst_s;
   wire cause_read_clear = rd_done && hit_cause && clear_ok;
   wire [7:0] cause_events = (8'(pin_s) << `RC_PIN) | (8'(wdt_s) << `RC_WATCHDOG)
      | (8'(illegal_opcode_flag_s) << `RC_ILLEGAL_OP) | (8'(illegal_address_flag_s) << `RC_ILLEGAL_ADDR)
      | (8'(monitor_set) << `RC_MONITOR) | (8'(lvi_s) << `RC_LOW_VOLTAGE);

   always_comb begin
      cause_d = cause_q;
      if (cause_read_clear) begin
         cause_d = 8'h00;
      end
      cause_d = cause_d | cause_events;
      if (por_s) begin
         cause_d = 8'(1) << `RC_POWER_ON;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         por_seen_q <= 1'b0;
      end else begin
         por_seen_q <= por_s ? 1'b1 : (monitor_set ? 1'b0 : por_seen_q);
      end
   end

   // cause flags survive the system reset that they explain
   always_ff @(posedge ref_clk) begin
      cause_q <= cause_d;
   end

   // break-in-standby flag: cleared by writing zero to it
   wire standby_break = in_break && (mode_q == MODE_WAIT || mode_q == MODE_STOP);
   wire standby_clear = wr_done && hit_bstat && !avs_writedata[`BSTAT_STANDBY_BIT] && clear_ok;
   always_comb begin
      standby_flag_d = standby_flag_q;
      if (standby_clear) begin
         standby_flag_d = 1'b0;
      end
      if (standby_break) begin
         standby_flag_d = 1'b1;
      end
   end

   // power mode sequencing
   wire [COUNT_WIDTH-1:0] rec_last = short_rec ? SHORT_LAST : LONG_LAST;
   wire recover_done = count_q == rec_last;
   wire wake_wait = irq_s || (in_break && emulation);
   wire wake_stop = irq_s || in_break;

   always_comb begin
      mode_d = mode_q;
      count_d = count_q + 1'b1;
      stack_d = 1'b0;
      case (mode_q)
         MODE_RUN: begin
            if (stop_exec) begin
               mode_d = MODE_STOP;
               count_d = '0;
            end else if (wait_exec) begin
               mode_d = MODE_WAIT;
            end
         end
         MODE_WAIT: begin
            if (wake_wait) begin
               mode_d = MODE_RUN;
               stack_d = irq_s;
            end
         end
         MODE_STOP: begin
            count_d = '0;
            if (wake_stop) begin
               mode_d = MODE_RECOVER;
            end
         end
         MODE_RECOVER: begin
            if (recover_done) begin
               mode_d = MODE_RUN;
               stack_d = 1'b1;
            end
         end
         default: begin
            mode_d = MODE_RUN;
         end
      endcase
   end

   // pin and other resets keep the counter running; only power-on reset restarts it
   wire counter_restart = por_s;
   always_ff @(posedge ref_clk) begin
      if (counter_restart) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   // executing wait or stop clears the global mask
   wire low_power_entry = mode_q == MODE_RUN && (wait_exec || stop_exec);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mode_q <= MODE_RUN;
         standby_flag_q <= 1'b0;
         mask_clear_q <= 1'b0;
         stack_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         standby_flag_q <= standby_flag_d;
         mask_clear_q <= low_power_entry;
         stack_q <= stack_d;
      end
   end

   // next values of the registered outputs
   wire next_run = mode_d == MODE_RUN;
   wire next_wait = mode_d == MODE_WAIT;
   wire next_stop = mode_d == MODE_STOP;
   wire next_watchdog = !ctl_q[`CTL_WATCHDOG_DISABLE] && !next_stop;

   // outputs, all registered
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cpu_clock_enable <= 1'b1;
         periph_clock_enable <= 1'b1;
         bus_clock_double_enable <= 1'b1;
         bus_clock_quad_enable <= 1'b1;
         watchdog_enable <= 1'b0;
         standby_mode <= 1'b0;
         power_state <= 2'h0;
         counter_value <= '0;
      end else begin
         cpu_clock_enable <= next_run;
         periph_clock_enable <= next_run || next_wait;
         bus_clock_double_enable <= !next_stop;
         bus_clock_quad_enable <= !next_stop;
         watchdog_enable <= next_watchdog;
         standby_mode <= !next_run;
         power_state <= mode_d;
         counter_value <= count_d;
      end
   end

   assign mask_clear = mask_clear_q;
   assign stack_start = stack_q;
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wreq_q;

   // peripheral status flag under break protection
   flag_guard_if fg ();
   assign fg.break_mode = in_break;
   assign fg.clear_enable = bfc_enable_q;
   assign fg.first_step = periph_clear_first;
   assign fg.second_step = periph_clear_second;
   assign fg.set_event = pset_s;

   flag_guard u_guard (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .fg(fg)
   );

   logic periph_flag_q;
   always_ff @(posedge ref_clk) begin
      periph_flag_q <= sys_rst ? 1'b0 : fg.flag;
   end
   assign periph_flag = periph_flag_q;
endmodule
`default_nettype wire

// ===== test/core_model.sv
// processor core model: runs low power instructions, counts mask clears and stackings
`timescale 1ns/1ns
`default_nettype none
module core_model (
   input wire logic ref_clk,
   input wire logic cmd_wait,
   input wire logic cmd_stop,
   input wire logic cpu_clock_enable,
   input wire logic mask_clear,
   input wire logic stack_start,
   output logic wait_exec,
   output logic stop_exec,
   output int mask_count,
   output int stack_count
);
   initial begin
      wait_exec = 0;
      stop_exec = 0;
      mask_count = 0;
      stack_count = 0;
   end
   // instructions only execute while the core is clocked
   always @(posedge ref_clk) begin
      wait_exec <= cmd_wait && cpu_clock_enable;
      stop_exec <= cmd_stop && cpu_clock_enable;
      if (mask_clear === 1'b1) mask_count <= mask_count + 1;
      if (stack_start === 1'b1) stack_count <= stack_count + 1;
   end
endmodule
`default_nettype wire

// ===== test/standby_reset_asserts.sv
// concurrent checks on the standby and reset status top ports
`timescale 1ns/1ns
`default_nettype none
module standby_reset_asserts #(
   parameter int LONG_RECOVERY = 4096,
   parameter int SHORT_RECOVERY = 32,
   parameter int COUNT_WIDTH = 13
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic break_irq,
   input wire logic mask_clear,
   input wire logic cpu_clock_enable,
   input wire logic periph_clock_enable,
   input wire logic bus_clock_double_enable,
   input wire logic bus_clock_quad_enable,
   input wire logic stack_start,
   input wire logic watchdog_enable,
   input wire logic [COUNT_WIDTH-1:0] counter_value,
   input wire logic [1:0] power_state
);
   import standby_reset_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   chk_answer_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_mask_entry: assert property (power_state == MODE_RUN && (wait_exec || stop_exec) |=> mask_clear)
      else $error("mask not cleared on low power entry");
   chk_wait_clocks: assert property (power_state == MODE_WAIT && $past(power_state) == MODE_WAIT && !$past(sys_rst)
      |-> !cpu_clock_enable && periph_clock_enable)
      else $error("wrong clock gating in wait");
   chk_stop_clocks: assert property (power_state == MODE_STOP && $past(power_state) == MODE_STOP && !$past(sys_rst)
      |-> !bus_clock_double_enable && !bus_clock_quad_enable && counter_value == 0)
      else $error("clocks or counter running in stop");
   chk_stop_no_stack: assert property (power_state == MODE_STOP |-> !stack_start)
      else $error("stacking during stop");
   chk_recover_count: assert property (power_state == MODE_RECOVER && $past(power_state) == MODE_RECOVER
      && !$past(sys_rst) |-> counter_value == $past(counter_value) + 1'b1)
      else $error("counter not timing recovery");
   chk_recover_end: assert property ($past(power_state) == MODE_RECOVER && power_state != MODE_RECOVER
      && !$past(sys_rst) |-> $past(counter_value) == LONG_RECOVERY - 1
      || $past(counter_value) == SHORT_RECOVERY - 1)
      else $error("recovery ended at wrong count");
   chk_wake_stack: assert property (power_state == MODE_WAIT && !break_irq ##1 power_state == MODE_RUN
      |-> ##[0:2] stack_start)
      else $error("no stacking after wake");
   chk_watchdog_wait: assert property (power_state == MODE_WAIT && $past(power_state) == MODE_WAIT
      && !$past(sys_rst) |-> $stable(watchdog_enable))
      else $error("watchdog changed in wait");
endmodule
bind standby_reset_status standby_reset_asserts #(.LONG_RECOVERY(LONG_RECOVERY),
   .SHORT_RECOVERY(SHORT_RECOVERY), .COUNT_WIDTH(COUNT_WIDTH)) chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .wait_exec(wait_exec),
   .stop_exec(stop_exec), .break_irq(break_irq), .mask_clear(mask_clear), .cpu_clock_enable(cpu_clock_enable),
   .periph_clock_enable(periph_clock_enable), .bus_clock_double_enable(bus_clock_double_enable),
   .bus_clock_quad_enable(bus_clock_quad_enable), .stack_start(stack_start),
   .watchdog_enable(watchdog_enable), .counter_value(counter_value), .power_state(power_state));
`default_nettype wire

// ===== test/tb.sv
// register and standby sequence tests of the standby and reset status block
`timescale 1ns/1ns
`default_nettype none
`include "standby_reset_defs.svh"
module tb;
   import standby_reset_pkg::*;
   localparam int LONG = 64;
   logic ref_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, irq_pending = 0, break_irq = 0;
   localparam int power_on = 0, flag_set = 1, cmd_wait = 2, cmd_stop = 3;
   logic clr1 = 0, clr2 = 0, tst = 0;
   logic [3:0] pl = '0;
   logic [17:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, rd;
   logic [4:0] ev = '0;
   logic [7:0] vec = 8'hFF;
   logic avs_waitrequest, periph_flag, wait_exec, stop_exec, mask_clear, cpu_en, per_en, dbl_en, quad_en;
   logic stack_start, wd_en, stby;
   logic [12:0] counter_value;
   logic [1:0] power_state;
   int mask_count, stack_count, err_total = 0, tests_run = 0, n, c0;
   always #10 ref_clk = ~ref_clk;
   standby_reset_status #(.LONG_RECOVERY(LONG)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wait_exec(wait_exec),
      .stop_exec(stop_exec), .irq_pending(irq_pending), .mask_clear(mask_clear), .cpu_clock_enable(cpu_en),
      .periph_clock_enable(per_en), .bus_clock_double_enable(dbl_en), .bus_clock_quad_enable(quad_en),
      .stack_start(stack_start), .watchdog_enable(wd_en), .counter_value(counter_value), .standby_mode(stby),
      .power_state(power_state), .break_irq(break_irq), .power_on_event(pl[power_on]), .pin_reset_event(ev[4]),
      .watchdog_reset_event(ev[3]), .illegal_op_event(ev[2]), .illegal_addr_event(ev[1]),
      .low_voltage_event(ev[0]), .irq_at_test_voltage(tst), .vector_high(vec), .vector_low(vec),
      .periph_flag_set(pl[flag_set]), .periph_clear_first(clr1), .periph_clear_second(clr2),
      .periph_flag(periph_flag));
   core_model core (.ref_clk(ref_clk), .cmd_wait(pl[cmd_wait]), .cmd_stop(pl[cmd_stop]), .cpu_clock_enable(cpu_en),
      .mask_clear(mask_clear), .stack_start(stack_start), .wait_exec(wait_exec), .stop_exec(stop_exec),
      .mask_count(mask_count), .stack_count(stack_count));
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
      n = 0;
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      check("wait_cycles", n, 2);
      avs_read <= 0;
      avs_write <= 0;
      tick(1);
   endtask
   task automatic rd_chk(input string name, input logic [15:0] idx, input logic [31:0] exp);
      bus(0, idx, 0);
      check(name, rd, exp);
   endtask
   task automatic pulse(input int k);
      pl[k] <= 1;
      tick(3);
      pl[k] <= 0;
      tick(5);
   endtask
   task automatic clear_steps(input logic a, input logic b);
      clr1 <= a;
      tick(1);
      clr1 <= 0;
      clr2 <= b;
      tick(1);
      clr2 <= 0;
      tick(2);
   endtask
   task automatic wait_for(input logic [1:0] s);
      n = 0;
      while (power_state !== s && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      check("power_state", power_state, s);
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #400000;
      check("timeout", 1, 0);
      print_verdict;
   end
   initial begin
      tick(4);
      sys_rst <= 0;
      tick(2);
      pulse(power_on);
      rd_chk("cause", `IDX_RESET_CAUSE, (1 << `RC_POWER_ON) | (1 << `RC_MONITOR));
      rd_chk("cause", `IDX_RESET_CAUSE, 0);
      for (int i = 0; i < 5; i++) begin
         ev <= 5'h01 << i;
         tick(3);
         ev <= 0;
         tick(5);
         rd_chk("cause", `IDX_RESET_CAUSE, 32'h1 << (i == 0 ? `RC_LOW_VOLTAGE : i + 2));
      end
      ev <= 5'h18;
      tick(3);
      ev <= 0;
      tick(5);
      rd_chk("cause", `IDX_RESET_CAUSE, (1 << `RC_PIN) | (1 << `RC_WATCHDOG));
      ev <= 5'h10;
      vec <= 8'h00;
      tick(4);
      ev <= 0;
      pulse(power_on);
      rd_chk("cause", `IDX_RESET_CAUSE, 1 << `RC_POWER_ON);
      vec <= 8'hFF;
      tst <= 1;
      pulse(power_on);
      rd_chk("cause", `IDX_RESET_CAUSE, 1 << `RC_POWER_ON);
      vec <= 8'h00;
      bus(1, 16'hFE02, 32'hFF);
      rd_chk("unmapped", 16'hFE02, 0);
      bus(1, `IDX_BREAK_FLAG_CLEAR, 32'hFF);
      rd_chk("clear_enable", `IDX_BREAK_FLAG_CLEAR, 32'h80);
      bus(1, `IDX_BREAK_FLAG_CLEAR, 0);
      pulse(flag_set);
      break_irq <= 1;
      tick(4);
      clear_steps(1, 1);
      check("flag", periph_flag, 1);
      bus(1, `IDX_BREAK_FLAG_CLEAR, 32'h80);
      clear_steps(1, 1);
      check("flag", periph_flag, 0);
      break_irq <= 0;
      tick(4);
      check("flag", periph_flag, 0);
      bus(1, `IDX_BREAK_FLAG_CLEAR, 0);
      pulse(flag_set);
      clear_steps(1, 0);
      break_irq <= 1;
      tick(4);
      clear_steps(0, 1);
      check("flag", periph_flag, 1);
      break_irq <= 0;
      tick(4);
      clear_steps(0, 1);
      check("flag", periph_flag, 0);
      c0 = mask_count;
      pulse(cmd_wait);
      wait_for(MODE_WAIT);
      check("mask", mask_count, c0 + 1);
      check("clocks", {cpu_en, per_en, wd_en}, 3'b011);
      check("standby", stby, 1);
      c0 = stack_count;
      irq_pending <= 1;
      wait_for(MODE_RUN);
      irq_pending <= 0;
      tick(3);
      check("stack", stack_count, c0 + 1);
      check("standby", stby, 0);
      bus(1, 16'hFE08, (1 << `CTL_EMULATION) | (1 << `CTL_WATCHDOG_DISABLE));
      pulse(cmd_wait);
      wait_for(MODE_WAIT);
      check("watchdog", wd_en, 0);
      break_irq <= 1;
      wait_for(MODE_RUN);
      break_irq <= 0;
      tick(4);
      rd_chk("break_status", `IDX_BREAK_STATUS, 1 << `BSTAT_STANDBY_BIT);
      for (int s = 0; s < 2; s++) begin
         bus(1, 16'hFE08, s);
         pulse(cmd_stop);
         wait_for(MODE_STOP);
         check("stop", {dbl_en, quad_en, counter_value}, 0);
         irq_pending <= 1;
         wait_for(MODE_RECOVER);
         n = 0;
         while (stack_start !== 1'b1 && n < 5000) begin
            @(posedge ref_clk);
            n++;
         end
         check("recovery", n, s ? `SHORT_RECOVERY_CYCLES : LONG);
         irq_pending <= 0;
         tick(4);
      end
      c0 = counter_value;
      ev <= 5'h10;
      tick(3);
      ev <= 0;
      tick(7);
      check("counter", counter_value, 13'(c0 + 10));
      print_verdict;
   end
endmodule
`default_nettype wire
